// ### cnm_chain.sv
// Top of the mixer, imbalance correction and DC offset chain, APB slave.
// Assumes samples synchronous to core_clk, one per cycle when valid.
// What this block does
// - Hold tuning and phase offset words; derive sine and cosine from them.
// - Clear phase accumulator on sync event chosen by two-bit select.
// - Add tuning word to accumulator every sample clock.
// - I out = I cos - Q sin, Q out = I sin + Q cos, scaled.
// - Phase offset word adds to phase; full range is one revolution.
// - Level clear gives sqrt2/2 gain, set gives sqrt2 gain.
// - Scale I and Q by eleven-bit unsigned path gains.
// - Q times signed ten-bit skew summed into I; range plus-minus one eighth.
// - DC offsets are thirteen-bit two's complement, independent per path.
// - Add DC offset LSB-aligned to each path before output.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cnm_defines.svh"
module cnm_chain
   import cnm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sync_pin,
   input wire logic tx_enable,
   input wire logic in_valid,
   input wire cnm_iq_t in_iq,
   output cnm_iq_t out_iq,
   output logic out_valid
);
   // ==========================================================
   // Reset release
   logic rst_m_q;
   logic rst_s_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
      if (v > 40'sd32767) begin
         sat16 = 16'sh7FFF;
      end else if (v < -40'sd32768) begin
         sat16 = 16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction : sat16

   // ==========================================================
   // Registers
   logic [31:0] freq_q;
   logic [15:0] phase_off_q;
   logic level_q;
   logic [1:0] sync_sel_q;
   logic sync_now_q;
   logic [10:0] gain_i_q;
   logic [10:0] gain_q_q;
   logic signed [9:0] skew_q;
   logic signed [12:0] dc_i_q;
   logic signed [12:0] dc_q_q;
   logic sat_seen_q;
   logic sat_now;
   logic wr_en;
   logic rd_en;
   logic bad_addr;
   // Writes land at the edge that completes the transfer
   assign wr_en = psel && penable && pwrite && pready;
   assign rd_en = psel && penable && !pwrite && !pready;

   always_comb begin
      bad_addr = 1'b0;
      if (paddr == `CNM_OFS_FREQ) begin
         bad_addr = 1'b0;
      end else if (paddr == `CNM_OFS_PHASE || paddr == `CNM_OFS_CTRL) begin
         bad_addr = 1'b0;
      end else if (paddr == `CNM_OFS_GAIN_I || paddr == `CNM_OFS_GAIN_Q) begin
         bad_addr = 1'b0;
      end else if (paddr == `CNM_OFS_SKEW || paddr == `CNM_OFS_DC_I) begin
         bad_addr = 1'b0;
      end else if (paddr == `CNM_OFS_DC_Q || paddr == `CNM_OFS_STATUS) begin
         bad_addr = 1'b0;
      end else begin
         bad_addr = 1'b1;
      end
   end

   // One wait state: answer in the second access cycle
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && bad_addr;
      end
   end

   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         freq_q <= 32'h0000_0000;
         phase_off_q <= 16'h0000;
         level_q <= 1'b0;
         sync_sel_q <= 2'b00;
         sync_now_q <= 1'b0;
         gain_i_q <= `CNM_GAIN_UNITY;
         gain_q_q <= `CNM_GAIN_UNITY;
         skew_q <= 10'sh000;
         dc_i_q <= 13'sh0000;
         dc_q_q <= 13'sh0000;
      end else begin
         sync_now_q <= 1'b0;
         if (wr_en) begin
            if (paddr == `CNM_OFS_FREQ) begin
               freq_q <= pwdata;
            end else if (paddr == `CNM_OFS_PHASE) begin
               phase_off_q <= pwdata[15:0];
            end else if (paddr == `CNM_OFS_CTRL) begin
               level_q <= pwdata[`CNM_CTRL_LEVEL_BIT];
               sync_sel_q <= pwdata[`CNM_CTRL_SYNC_HI:`CNM_CTRL_SYNC_LO];
               sync_now_q <= pwdata[`CNM_CTRL_SYNC_NOW];
            end else if (paddr == `CNM_OFS_GAIN_I) begin
               gain_i_q <= pwdata[10:0];
            end else if (paddr == `CNM_OFS_GAIN_Q) begin
               gain_q_q <= pwdata[10:0];
            end else if (paddr == `CNM_OFS_SKEW) begin
               skew_q <= pwdata[9:0];
            end else if (paddr == `CNM_OFS_DC_I) begin
               dc_i_q <= pwdata[12:0];
            end else if (paddr == `CNM_OFS_DC_Q) begin
               dc_q_q <= pwdata[12:0];
            end
         end
      end
   end

   // Status: sticky saturation, set wins over read-clear
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         sat_seen_q <= 1'b0;
      end else if (sat_now) begin
         sat_seen_q <= 1'b1;
      end else if (rd_en && paddr == `CNM_OFS_STATUS) begin
         sat_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         if (paddr == `CNM_OFS_FREQ) begin
            prdata <= freq_q;
         end else if (paddr == `CNM_OFS_PHASE) begin
            prdata <= {16'h0000, phase_off_q};
         end else if (paddr == `CNM_OFS_CTRL) begin
            prdata <= {29'h0000_0000, sync_sel_q, level_q};
         end else if (paddr == `CNM_OFS_GAIN_I) begin
            prdata <= {21'h00_0000, gain_i_q};
         end else if (paddr == `CNM_OFS_GAIN_Q) begin
            prdata <= {21'h00_0000, gain_q_q};
         end else if (paddr == `CNM_OFS_SKEW) begin
            prdata <= {22'h00_0000, skew_q};
         end else if (paddr == `CNM_OFS_DC_I) begin
            prdata <= {19'h0_0000, dc_i_q};
         end else if (paddr == `CNM_OFS_DC_Q) begin
            prdata <= {19'h0_0000, dc_q_q};
         end else if (paddr == `CNM_OFS_STATUS) begin
            prdata <= {31'h0000_0000, sat_seen_q};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Oscillator
   logic [31:0] acc_q;
   logic sync_pin_q;
   logic tx_en_q;
   logic sync_evt;
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         sync_pin_q <= 1'b0;
         tx_en_q <= 1'b0;
      end else begin
         sync_pin_q <= sync_pin;
         tx_en_q <= tx_enable;
      end
   end
   always_comb begin
      case (cnm_sync_sel_t'(sync_sel_q))
         CNM_SYNC_SW: sync_evt = sync_now_q;
         CNM_SYNC_PIN: sync_evt = sync_pin && !sync_pin_q;
         CNM_SYNC_TXEN: sync_evt = tx_enable && !tx_en_q;
         default: sync_evt = 1'b0;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         acc_q <= 32'h0000_0000;
      end else if (sync_evt) begin
         acc_q <= 32'h0000_0000;
      end else begin
         acc_q <= acc_q + freq_q;
      end
   end

   logic [15:0] nco_phase;
   logic signed [15:0] sin_v;
   logic signed [15:0] cos_v;
   assign nco_phase = acc_q[31:16] + phase_off_q;
   cnm_sincos u_sincos (
      .core_clk(core_clk),
      .rst_n(rst_s_q),
      .phase(nco_phase),
      .sin_q(sin_v),
      .cos_q(cos_v)
   );

   // ==========================================================
   // Stage 1: align samples with table latency
   cnm_iq_t s1_q;
   logic v1_q;
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         s1_q <= '0;
         v1_q <= 1'b0;
      end else begin
         s1_q <= in_iq;
         v1_q <= in_valid;
      end
   end

   // Stage 2: mixer; table is Q1.14, product scaled by sqrt2/2, so shift gives level
   logic signed [39:0] mi;
   logic signed [39:0] mq;
   cnm_iq_t s2_q;
   logic v2_q;
   always_comb begin
      mi = 40'(s1_q.i) * 40'(cos_v) - 40'(s1_q.q) * 40'(sin_v);
      mq = 40'(s1_q.i) * 40'(sin_v) + 40'(s1_q.q) * 40'(cos_v);
      // Drop 13 bits first so the sqrt2 product stays inside 40 bits
      mi = (mi >>> 13) * 40'sd23170;
      mq = (mq >>> 13) * 40'sd23170;
      // Level 0: x*0.7071, level 1: x*1.4142
      mi = level_q ? (mi >>> 15) : (mi >>> 16);
      mq = level_q ? (mq >>> 15) : (mq >>> 16);
   end
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         s2_q <= '0;
         v2_q <= 1'b0;
      end else begin
         s2_q.i <= sat16(mi);
         s2_q.q <= sat16(mq);
         v2_q <= v1_q;
      end
   end

   // Stage 3: gains, Q1.10 unsigned, and phase skew Q.12 signed
   logic signed [39:0] gi;
   logic signed [39:0] gq;
   cnm_iq_t s3_q;
   logic v3_q;
   always_comb begin
      gi = (40'(s2_q.i) * 40'(signed'({1'b0, gain_i_q}))) >>> 10;
      gq = (40'(s2_q.q) * 40'(signed'({1'b0, gain_q_q}))) >>> 10;
      gi = gi + ((40'(s2_q.q) * 40'(skew_q)) >>> 12);
   end
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         s3_q <= '0;
         v3_q <= 1'b0;
      end else begin
         s3_q.i <= sat16(gi);
         s3_q.q <= sat16(gq);
         v3_q <= v2_q;
      end
   end

   // Stage 4: DC offset
   logic signed [39:0] oi;
   logic signed [39:0] oq;
   always_comb begin
      oi = 40'(s3_q.i) + 40'(dc_i_q);
      oq = 40'(s3_q.q) + 40'(dc_q_q);
   end
   assign sat_now = v3_q && (oi != 40'(sat16(oi)) || oq != 40'(sat16(oq)));
   always_ff @(posedge core_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         out_iq <= '0;
         out_valid <= 1'b0;
      end else begin
         out_iq.i <= sat16(oi);
         out_iq.q <= sat16(oq);
         out_valid <= v3_q;
      end
   end
endmodule : cnm_chain
`default_nettype wire

// ### cnm_chain_chk.sv
// Port checker for the mixer and correction chain.
// Assumes a bind onto cnm_chain from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "cnm_defines.svh"
module cnm_chain_chk
   import cnm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sync_pin,
   input wire logic tx_enable,
   input wire logic in_valid,
   input wire cnm_iq_t in_iq,
   input wire cnm_iq_t out_iq,
   input wire logic out_valid
);
   // ==========================================
   // Assertions
   logic [3:0] up_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 4'h0;
      end else if (!up_q[3]) begin
         up_q <= up_q + 4'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_valid_delay: assert property (up_q[3] |-> out_valid == $past(in_valid, 4))
      else $error("out_valid is not in_valid four cycles late");
   a_ready_time: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   a_err_unmapped: assert property (pready && paddr > `CNM_OFS_STATUS |-> pslverr)
      else $error("no pslverr on unmapped address");
   a_err_mapped: assert property (pready && paddr <= `CNM_OFS_STATUS && paddr[1:0] == 2'b00
      |-> !pslverr) else $error("pslverr on mapped address");
   a_err_pulse: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n && $past(!rst_n)
      |-> !out_valid && !pready)
      else $error("outputs active in reset");
   c_unmapped: cover property (pready && pslverr);
   c_write: cover property (pready && pwrite);
   c_stream: cover property (out_valid && !$past(out_valid));
endmodule : cnm_chain_chk
`default_nettype wire

// ### cnm_chain_tb_top.sv
// Self-checking bench for the mixer and correction chain.
// Assumes the design files, the source model and the checker.
`timescale 1ns/1ps
`default_nettype none
`include "cnm_defines.svh"
module cnm_chain_tb_top
   import cnm_pkg::*;
;
   // ==========================================
   // Harness
   logic core_clk, rst_n, psel, penable, pwrite, sync_pin, tx_enable, slow;
   logic in_valid, out_valid, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [17:0] oi, oq, a, b;
   cnm_iq_t smp, in_iq, out_iq;
   int err_total, n_checks;
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   cnm_src cnm_src_i (.core_clk(core_clk), .rst_n(rst_n), .smp(smp), .slow(slow),
      .in_iq(in_iq), .in_valid(in_valid));
   cnm_chain cnm_chain_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_pin(sync_pin), .tx_enable(tx_enable), .in_valid(in_valid),
      .in_iq(in_iq), .out_iq(out_iq), .out_valid(out_valid));
   task results;
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   task chk_x(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_x
   task chk_n(input logic signed [17:0] got, input int exp, input int tol);
      n_checks++;
      if ($isunknown(got) || got > exp + tol || got < exp - tol) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_n
   task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [11:0] ad, input logic [31:0] d);
      xfer(1'b1, ad, d);
   endtask : wr
   task rdc(input logic [11:0] ad, input logic [31:0] exp);
      xfer(1'b0, ad, 32'h0000_0000);
      chk_x(rd, exp);
   endtask : rdc
   task look(input logic signed [15:0] i, input logic signed [15:0] q);
      int n;
      n = 0;
      smp <= {i, q};
      repeat (10) @(posedge core_clk);
      while (out_valid !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20) err_total++;
      oi = out_iq.i;
      oq = out_iq.q;
   endtask : look
   task mix(input logic [31:0] ph, input logic signed [15:0] i, q, input int ei, eq);
      wr(`CNM_OFS_PHASE, ph);
      look(i, q);
      chk_n(oi, ei, 8);
      chk_n(oq, eq, 8);
   endtask : mix
   task t_sync(input logic [1:0] sel);
      wr(`CNM_OFS_FREQ, 32'h1357_9BDF);
      wr(`CNM_OFS_FREQ, 32'h0000_0000);
      wr(`CNM_OFS_CTRL, {28'h0000_000, sel == 2'b00, sel, 1'b0});
      sync_pin <= sel == 2'b01;
      tx_enable <= sel == 2'b10;
      repeat (3) @(posedge core_clk);
      sync_pin <= 1'b0;
      tx_enable <= 1'b0;
      look(16'sd16384, 16'sd0);
      chk_n(oi, 11585, 8);
      chk_n(oq, 0, 8);
   endtask : t_sync
   task t_hold;
      // Four cycles of an eighth-turn step leave the phase at a half turn
      wr(`CNM_OFS_FREQ, 32'h2000_0000);
      wr(`CNM_OFS_FREQ, 32'h0000_0000);
      wr(`CNM_OFS_CTRL, 32'h0000_000E);
      sync_pin <= 1'b1;
      tx_enable <= 1'b1;
      repeat (3) @(posedge core_clk);
      sync_pin <= 1'b0;
      tx_enable <= 1'b0;
      look(16'sd16384, 16'sd0);
      chk_n(oi, -11585, 8);
      chk_n(oq, 0, 8);
   endtask : t_hold
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      results();
   end
   initial begin
      {rst_n, psel, penable, pwrite, sync_pin, tx_enable, slow} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      smp = '0;
      err_total = 0;
      n_checks = 0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rdc(`CNM_OFS_GAIN_I, 32'h0000_0400);
      rdc(`CNM_OFS_GAIN_Q, 32'h0000_0400);
      rdc(`CNM_OFS_FREQ, 32'h0000_0000);
      rdc(12'h024, 32'h0000_0000);
      chk_x({31'h0, er}, 32'h0000_0001);
      // Offset stage, then clipping at raised mixer level
      wr(`CNM_OFS_DC_I, 32'h0000_0FFF);
      wr(`CNM_OFS_DC_Q, 32'h0000_1000);
      mix(32'h0000_0000, 16'sd0, 16'sd0, 4095, -4096);
      wr(`CNM_OFS_CTRL, 32'h0000_0001);
      look(16'sd32767, 16'sd0);
      chk_n(oi, 32767, 0);
      chk_n(oq, -4096, 0);
      rdc(`CNM_OFS_STATUS, 32'h0000_0001);
      wr(`CNM_OFS_DC_I, 32'h0000_0000);
      wr(`CNM_OFS_DC_Q, 32'h0000_0000);
      mix(32'h0000_2000, 16'sd8192, 16'sd0, 8192, 8192);
      wr(`CNM_OFS_GAIN_I, 32'h0000_0200);
      wr(`CNM_OFS_GAIN_Q, 32'h0000_0600);
      mix(32'h0000_2000, 16'sd8192, 16'sd0, 4096, 12288);
      wr(`CNM_OFS_GAIN_I, 32'h0000_0400);
      wr(`CNM_OFS_GAIN_Q, 32'h0000_0400);
      wr(`CNM_OFS_SKEW, 32'h0000_01FF);
      mix(32'h0000_0000, 16'sd0, 16'sd8192, 1445, 11585);
      wr(`CNM_OFS_SKEW, 32'h0000_0200);
      mix(32'h0000_0000, 16'sd0, 16'sd8192, -1448, 11585);
      wr(`CNM_OFS_SKEW, 32'h0000_0000);
      wr(`CNM_OFS_CTRL, 32'h0000_0000);
      mix(32'h0000_0000, 16'sd16384, 16'sd0, 11585, 0);
      mix(32'h0000_4000, 16'sd16384, 16'sd0, 0, 11585);
      mix(32'h0000_8000, 16'sd16384, 16'sd0, -11585, 0);
      mix(32'h0000_4000, 16'sd0, 16'sd16384, -11585, 0);
      mix(32'h0000_0000, 16'sd16384, 16'sd0, 11585, 0);
      // Half-turn step flips the sign every sample
      wr(`CNM_OFS_FREQ, 32'h8000_0000);
      look(16'sd16384, 16'sd0);
      @(posedge core_clk);
      a = out_iq.i;
      @(posedge core_clk);
      b = out_iq.i;
      chk_n(a + b, 0, 16);
      chk_n((a < 0) ? -a : a, 11585, 8);
      t_sync(2'b00);
      t_sync(2'b01);
      t_sync(2'b10);
      t_hold();
      slow <= 1'b1;
      repeat (40) @(posedge core_clk);
      slow <= 1'b0;
      wr(`CNM_OFS_SKEW, 32'h0000_FFFF);
      rdc(`CNM_OFS_SKEW, 32'h0000_03FF);
      wr(`CNM_OFS_DC_Q, 32'hFFFF_FFFF);
      rdc(`CNM_OFS_DC_Q, 32'h0000_1FFF);
      wr(`CNM_OFS_GAIN_I, 32'hFFFF_FFFF);
      rdc(`CNM_OFS_GAIN_I, 32'h0000_07FF);
      wr(`CNM_OFS_PHASE, 32'h1234_ABCD);
      rdc(`CNM_OFS_PHASE, 32'h0000_ABCD);
      results();
   end
endmodule : cnm_chain_tb_top
bind cnm_chain cnm_chain_chk cnm_chain_chk_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin), .tx_enable(tx_enable),
   .in_valid(in_valid), .in_iq(in_iq), .out_iq(out_iq), .out_valid(out_valid));
`default_nettype wire

// ### cnm_defines.svh
// Constants for the complex mixer and imbalance correction chain.
// Assumes inclusion by bare name; definitions only.
`ifndef CNM_DEFINES_SVH
`define CNM_DEFINES_SVH
// ==========================================================
// Register byte offsets
`define CNM_OFS_FREQ 12'h000
`define CNM_OFS_PHASE 12'h004
`define CNM_OFS_CTRL 12'h008
`define CNM_OFS_GAIN_I 12'h00C
`define CNM_OFS_GAIN_Q 12'h010
`define CNM_OFS_SKEW 12'h014
`define CNM_OFS_DC_I 12'h018
`define CNM_OFS_DC_Q 12'h01C
`define CNM_OFS_STATUS 12'h020
// ==========================================================
// Reset values and field positions
`define CNM_GAIN_UNITY 11'h400
`define CNM_CTRL_LEVEL_BIT 0
`define CNM_CTRL_SYNC_LO 1
`define CNM_CTRL_SYNC_HI 2
`define CNM_CTRL_SYNC_NOW 3
// ==========================================================
// Timing
`define CNM_CLK_PERIOD_NS 10
`define CNM_PIPE_DEPTH 4
`endif

// ### cnm_pkg.sv
// Types for the complex mixer and imbalance correction chain.
// Assumes nothing beyond the defines header.
package cnm_pkg;
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } cnm_iq_t;
   typedef enum logic [1:0] {
      CNM_SYNC_SW = 2'b00,
      CNM_SYNC_PIN = 2'b01,
      CNM_SYNC_TXEN = 2'b10,
      CNM_SYNC_NONE = 2'b11
   } cnm_sync_sel_t;
   typedef enum logic [2:0] {
      CNM_APB_IDLE = 3'b001,
      CNM_APB_SETUP = 3'b010,
      CNM_APB_ACCESS = 3'b100
   } cnm_apb_state_t;
endpackage : cnm_pkg

// ### cnm_sincos.sv
// Sine and cosine from a 16-bit phase, one cycle latency, Q1.14.
// Assumes a quarter-wave table built at elaboration.
`timescale 1ns/1ps
`default_nettype none
module cnm_sincos
   import cnm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] phase,
   output logic signed [15:0] sin_q,
   output logic signed [15:0] cos_q
);
   // Quarter wave plus end point, so zero and full scale are exact
   logic signed [15:0] rom [0:1024];
   logic [10:0] idx_s;
   logic [10:0] idx_c;
   logic [10:0] idx_f;
   logic [10:0] idx_m;
   logic [1:0] quad;
   initial begin
      for (int k = 0; k <= 1024; k++) begin
         rom[k] = 16'($rtoi(16383.0 * $sin(3.14159265358979 * k / 2048.0) + 0.5));
      end
   end
   assign quad = phase[15:14];
   assign idx_f = {1'b0, phase[13:4]};
   assign idx_m = 11'h400 - idx_f;
   assign idx_s = quad[0] ? idx_m : idx_f;
   assign idx_c = quad[0] ? idx_f : idx_m;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sin_q <= 16'sh0000;
         cos_q <= 16'sh0000;
      end else begin
         sin_q <= quad[1] ? -rom[idx_s] : rom[idx_s];
         cos_q <= (quad[1] ^ quad[0]) ? -rom[idx_c] : rom[idx_c];
      end
   end
endmodule : cnm_sincos
`default_nettype wire

// ### cnm_src.sv
// Upstream sample source model feeding the chain.
// Assumes the bench sets smp and slow; slow gives every other cycle.
`timescale 1ns/1ps
`default_nettype none
module cnm_src
   import cnm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire cnm_iq_t smp,
   input wire logic slow,
   output cnm_iq_t in_iq,
   output logic in_valid
);
   // ==========================================
   // Stream
   logic tog_q;
   logic v;
   assign v = !slow || tog_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_q <= 1'b0;
         in_valid <= 1'b0;
         in_iq <= '0;
      end else begin
         tog_q <= !tog_q;
         in_valid <= v;
         // Idle cycles carry garbage, not stale data
         in_iq <= v ? smp : ~smp;
      end
   end
endmodule : cnm_src
`default_nettype wire
